/* File: rtl/ald_regs.svh */
// register offsets, field positions, reset values and constants of the datapath
`ifndef ALD_REGS_SVH
`define ALD_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ALD_DEST_OFFS    12'h000
`define ALD_SRC_OFFS     12'h004
`define ALD_PAIR_HI_OFFS 12'h008
`define ALD_FLAGS_OFFS   12'h00c
`define ALD_CMD_OFFS     12'h010
`define ALD_STAT_OFFS    12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ALD_CMD_OP_MSB   3
`define ALD_STAT_BUSY    0
`define ALD_STAT_ILLEGAL 1
`define ALD_WIMM_MSB     5

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define ALD_DATA_RST     8'h00
`define ALD_FLAGS_RST    6'h00
`define ALD_OP_RST       4'h0
`define ALD_OP_LAST      4'he
`define ALD_ALL_ONES     8'hff

`endif

/* File: rtl/ald_pkg.sv */
// types shared by the arithmetic and logic datapath
package ald_pkg;

  // operation codes, in command register order
  typedef enum logic [3:0] {
    op_add,
    op_add_carry,
    op_sub,
    op_subtract_constant,
    op_subtract_with_borrow,
    op_subtract_constant_with_borrow,
    op_word_immediate_sum,
    op_word_immediate_difference,
    op_and,
    op_mask_with_constant,
    op_or,
    op_merge_with_constant,
    op_zero_or_minus_check,
    op_bit_set_by_mask,
    op_bit_clear_by_mask
  } ald_op_t;

  // status flags; c in bit 0 up to h in bit 5
  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } ald_flags_t;

  // byte adder outcome
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       h;
    logic       v;
  } ald_sum_t;

  typedef enum {st_idle, st_exec, st_word_hi} ald_state_t;

endpackage

/* File: rtl/ald_arith_logic_datapath.sv */
// 8-bit arithmetic and logic datapath with apb register access
//
// Summary of operation
// RULE1: add two bytes, optional carry in; update z,c,n,v,h; one cycle
// RULE2: register minus constant stored; update z,c,n,v,h; one cycle
// RULE3: register minus source minus carry stored; update z,c,n,v,h; one cycle
// RULE4: register minus constant minus carry stored; update z,c,n,v,h; one cycle
// RULE5: pair plus immediate into 16-bit pair; update z,c,n,v,s; two cycles
// RULE6: pair minus immediate, both halves written; update z,c,n,v,s; two cycles
// RULE7: and with register or constant; update z,n,v only; one cycle
// RULE8: or with register or constant; update z,n,v only; one cycle
// RULE9: test ands register with itself, value kept; update z,n,v; one cycle
// RULE10: bit set ors register with mask; update z,n,v; one cycle
// RULE11: bit clear ands with ff minus mask; update z,n,v; one cycle
// RULE12: flags not touched by an operation keep their value
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ald_regs.svh"
`default_nettype none

module ald_arith_logic_datapath (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core side status
  output logic                   busy,
  output ald_pkg::ald_flags_t    flags
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // byte add with carry in, half carry and overflow
  function automatic ald_pkg::ald_sum_t add8(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       ci);
    ald_pkg::ald_sum_t o;
    logic [8:0]        t;
    logic [4:0]        lo;
    t     = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    o.res = t[7:0];
    o.c   = t[8];
    o.h   = lo[4];
    o.v   = (a[7] & b[7] & ~t[7]) | (~a[7] & ~b[7] & t[7]);
    return o;
  endfunction

  // byte subtract with borrow in; c and h become borrows
  function automatic ald_pkg::ald_sum_t sub8(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       bi);
    ald_pkg::ald_sum_t o;
    o   = add8(a, ~b, ~bi);
    o.c = ~o.c;
    o.h = ~o.h;
    return o;
  endfunction

  // address decode
  function automatic logic mapped(input logic [11:0] a);
    return a == `ALD_DEST_OFFS || a == `ALD_SRC_OFFS || a == `ALD_PAIR_HI_OFFS ||
           a == `ALD_FLAGS_OFFS || a == `ALD_CMD_OFFS || a == `ALD_STAT_OFFS;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ald_pkg::ald_state_t state_reg, state_next;
  ald_pkg::ald_op_t    op_reg, op_next;
  ald_pkg::ald_flags_t flags_reg, flags_next;
  logic [7:0]          dest_reg, dest_next;
  logic [7:0]          src_reg, src_next;
  logic [7:0]          pair_hi_reg, pair_hi_next;
  logic                wcarry_reg, wcarry_next;
  logic                illegal_reg, illegal_next;
  logic [31:0]         prdata_reg, prdata_next;
  logic                wr_ok;
  logic                ex;
  ald_pkg::ald_sum_t   s8;
  logic [7:0]          lres;
  logic [7:0]          wimm;

  // apb handshake: zero wait states, errors on unmapped reads or writes and on busy writes
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (~mapped(paddr) | (pwrite & busy));
  assign wr_ok   = psel & penable & pwrite & mapped(paddr) & ~busy & pstrb[0];
  assign busy    = state_reg != ald_pkg::st_idle;
  assign ex      = state_reg == ald_pkg::st_exec;
  assign flags   = flags_reg;
  assign prdata  = prdata_reg;
  assign wimm    = {2'b00, src_reg[`ALD_WIMM_MSB:0]};

  // ----------------------------------------------------------------
  // next-state and datapath
  // ----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    op_next      = op_reg;
    flags_next   = flags_reg; // RULE12
    dest_next    = dest_reg;
    src_next     = src_reg;
    pair_hi_next = pair_hi_reg;
    wcarry_next  = wcarry_reg;
    illegal_next = illegal_reg;
    prdata_next  = prdata_reg;
    s8           = add8(dest_reg, src_reg, 1'b0);
    lres         = dest_reg;

    // read data captured in the setup phase
    if (psel & ~penable) begin
      unique case (paddr)
        `ALD_DEST_OFFS:    prdata_next = {24'h000000, dest_reg};
        `ALD_SRC_OFFS:     prdata_next = {24'h000000, src_reg};
        `ALD_PAIR_HI_OFFS: prdata_next = {24'h000000, pair_hi_reg};
        `ALD_FLAGS_OFFS:   prdata_next = {26'h0000000, flags_reg};
        `ALD_CMD_OFFS:     prdata_next = {28'h0000000, op_reg};
        `ALD_STAT_OFFS:    prdata_next = {30'h00000000, illegal_reg, busy};
        default:           prdata_next = 32'h00000000;
      endcase
    end

    // register writes while idle
    if (wr_ok) begin
      unique case (paddr)
        `ALD_DEST_OFFS:    dest_next = pwdata[7:0];
        `ALD_SRC_OFFS:     src_next = pwdata[7:0];
        `ALD_PAIR_HI_OFFS: pair_hi_next = pwdata[7:0];
        `ALD_FLAGS_OFFS:   flags_next = pwdata[5:0];
        `ALD_CMD_OFFS: begin
          if (pwdata[`ALD_CMD_OP_MSB:0] <= `ALD_OP_LAST) begin
            op_next      = ald_pkg::ald_op_t'(pwdata[`ALD_CMD_OP_MSB:0]);
            illegal_next = 1'b0;
            state_next   = ald_pkg::st_exec;
          end else begin
            illegal_next = 1'b1;
          end
        end
        default: illegal_next = 1'b1; // status is read-only
      endcase
    end

    // execution
    unique case (state_reg)
      ald_pkg::st_idle: begin
      end
      ald_pkg::st_exec: begin
        state_next = ald_pkg::st_idle;
        unique case (op_reg)
          ald_pkg::op_add:
            s8 = add8(dest_reg, src_reg, 1'b0); // RULE1
          ald_pkg::op_add_carry:
            s8 = add8(dest_reg, src_reg, flags_reg.c); // RULE1
          ald_pkg::op_sub, ald_pkg::op_subtract_constant:
            s8 = sub8(dest_reg, src_reg, 1'b0); // RULE2
          ald_pkg::op_subtract_with_borrow:
            s8 = sub8(dest_reg, src_reg, flags_reg.c); // RULE3
          ald_pkg::op_subtract_constant_with_borrow:
            s8 = sub8(dest_reg, src_reg, flags_reg.c); // RULE4
          ald_pkg::op_word_immediate_sum:
            s8 = add8(dest_reg, wimm, 1'b0); // RULE5
          ald_pkg::op_word_immediate_difference:
            s8 = sub8(dest_reg, wimm, 1'b0); // RULE6
          ald_pkg::op_and, ald_pkg::op_mask_with_constant:
            lres = dest_reg & src_reg; // RULE7
          ald_pkg::op_or, ald_pkg::op_merge_with_constant:
            lres = dest_reg | src_reg; // RULE8
          ald_pkg::op_zero_or_minus_check:
            lres = dest_reg & dest_reg; // RULE9
          ald_pkg::op_bit_set_by_mask:
            lres = dest_reg | src_reg; // RULE10
          ald_pkg::op_bit_clear_by_mask:
            lres = dest_reg & (`ALD_ALL_ONES - src_reg); // RULE11
          default: lres = dest_reg;
        endcase
        if (op_reg <= ald_pkg::op_subtract_constant_with_borrow) begin
          // byte arithmetic: z,c,n,v,h; s kept
          dest_next    = s8.res;
          flags_next.z = s8.res == 8'h00;
          flags_next.c = s8.c;
          flags_next.n = s8.res[7];
          flags_next.v = s8.v;
          flags_next.h = s8.h;
        end else if (op_reg == ald_pkg::op_word_immediate_sum ||
                     op_reg == ald_pkg::op_word_immediate_difference) begin
          // low half now, high half and flags next cycle
          dest_next   = s8.res;
          wcarry_next = s8.c;
          state_next  = ald_pkg::st_word_hi;
        end else begin
          // logic group: z,n from result, v cleared; others kept
          dest_next    = lres;
          flags_next.z = lres == 8'h00;
          flags_next.n = lres[7];
          flags_next.v = 1'b0;
        end
      end
      ald_pkg::st_word_hi: begin
        state_next = ald_pkg::st_idle;
        if (op_reg == ald_pkg::op_word_immediate_sum) begin
          s8           = add8(pair_hi_reg, 8'h00, wcarry_reg);
          flags_next.v = ~pair_hi_reg[7] & s8.res[7]; // RULE5
          flags_next.c = ~s8.res[7] & pair_hi_reg[7];
        end else begin
          s8           = sub8(pair_hi_reg, 8'h00, wcarry_reg);
          flags_next.v = pair_hi_reg[7] & ~s8.res[7]; // RULE6
          flags_next.c = s8.res[7] & ~pair_hi_reg[7];
        end
        pair_hi_next = s8.res;
        flags_next.z = {s8.res, dest_reg} == 16'h0000;
        flags_next.n = s8.res[7];
        flags_next.s = s8.res[7] ^ flags_next.v;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ald_pkg::st_idle;
      op_reg      <= ald_pkg::ald_op_t'(`ALD_OP_RST);
      flags_reg   <= `ALD_FLAGS_RST;
      dest_reg    <= `ALD_DATA_RST;
      src_reg     <= `ALD_DATA_RST;
      pair_hi_reg <= `ALD_DATA_RST;
      wcarry_reg  <= 1'b0;
      illegal_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      flags_reg   <= flags_next;
      dest_reg    <= dest_next;
      src_reg     <= src_next;
      pair_hi_reg <= pair_hi_next;
      wcarry_reg  <= wcarry_next;
      illegal_reg <= illegal_next;
      prdata_reg  <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_add_sum: assert property (ex && op_reg == ald_pkg::op_add_carry |=> // RULE1
    dest_reg == 8'($past(dest_reg) + $past(src_reg) + {7'h00, $past(flags_reg.c)})
    && flags_reg.s == $past(flags_reg.s) && !busy)
    else $error("add with carry result wrong");

  a_subtract_constant_diff: assert property (ex && op_reg == ald_pkg::op_subtract_constant |=> // RULE2
    dest_reg == 8'($past(dest_reg) - $past(src_reg))
    && flags_reg.c == ($past(src_reg) > $past(dest_reg)))
    else $error("subtract constant wrong");

  a_sbc_borrow: assert property (ex && op_reg == ald_pkg::op_subtract_with_borrow |=> // RULE3
    dest_reg == 8'($past(dest_reg) - $past(src_reg) - {7'h00, $past(flags_reg.c)})
    && flags_reg.z == (dest_reg == 8'h00))
    else $error("subtract with borrow wrong");

  a_subtract_constant_with_borrow_diff: assert property (ex && op_reg == ald_pkg::op_subtract_constant_with_borrow // RULE4
    |=> dest_reg == 8'($past(dest_reg) - $past(src_reg) - {7'h00, $past(flags_reg.c)})
    && flags_reg.n == dest_reg[7])
    else $error("subtract constant with borrow wrong");

  a_word_sum: assert property (ex && op_reg == ald_pkg::op_word_immediate_sum |=> // RULE5
    state_reg == ald_pkg::st_word_hi ##1 !busy &&
    {pair_hi_reg, dest_reg} == 16'({$past(pair_hi_reg, 2), $past(dest_reg, 2)}
    + {10'h000, $past(src_reg[5:0], 2)}) && flags_reg.s == (flags_reg.n ^ flags_reg.v))
    else $error("word sum wrong");

  a_word_diff: assert property (ex && op_reg == ald_pkg::op_word_immediate_difference |=> // RULE6
    ##1 !busy && {pair_hi_reg, dest_reg} == 16'({$past(pair_hi_reg, 2),
    $past(dest_reg, 2)} - {10'h000, $past(src_reg[5:0], 2)})
    && flags_reg.h == $past(flags_reg.h, 2))
    else $error("word difference wrong");

  a_and_v: assert property (ex && op_reg == ald_pkg::op_mask_with_constant |=> // RULE7
    dest_reg == ($past(dest_reg) & $past(src_reg)) && !flags_reg.v)
    else $error("and with constant wrong");

  a_or_res: assert property (ex && op_reg == ald_pkg::op_or |=> // RULE8
    dest_reg == ($past(dest_reg) | $past(src_reg)) && !flags_reg.v)
    else $error("or of registers wrong");

  a_test_keep: assert property (ex && op_reg == ald_pkg::op_zero_or_minus_check |=> // RULE9
    $stable(dest_reg) && flags_reg.z == (dest_reg == 8'h00) && flags_reg.n == dest_reg[7])
    else $error("test changed value or flags wrong");

  a_set_bits: assert property (ex && op_reg == ald_pkg::op_bit_set_by_mask |=> // RULE10
    dest_reg == ($past(dest_reg) | $past(src_reg)))
    else $error("bit set wrong");

  a_clear_bits: assert property (ex && op_reg == ald_pkg::op_bit_clear_by_mask |=> // RULE11
    dest_reg == ($past(dest_reg) & ~$past(src_reg)))
    else $error("bit clear wrong");

  a_keep_flags: assert property (ex && op_reg >= ald_pkg::op_and |=> // RULE12
    flags_reg.c == $past(flags_reg.c) && flags_reg.h == $past(flags_reg.h)
    && flags_reg.s == $past(flags_reg.s))
    else $error("untouched flag changed");

endmodule

`default_nettype wire

/* File: tb/ald_decoder_model.sv */
// apb master standing in for the instruction decoder and register file
`timescale 1ns/1ps
`default_nettype none

module ald_decoder_model (
  // clock
  input  wire logic        pclk,
  // apb master side
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ----------------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
  end

  // one transfer, entered just past a rising edge; request held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      input logic [3:0] st, output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
  endtask

  // release the bus for one cycle
  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

`default_nettype wire

/* File: tb/ald_arith_logic_datapath_tb.sv */
// self-checking testbench of the arithmetic and logic datapath
`timescale 1ns/1ps
`include "ald_regs.svh"
`default_nettype none

module ald_arith_logic_datapath_tb;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [3:0]          pstrb;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                busy;
  ald_pkg::ald_flags_t flags;
  int                  n_fail;
  int                  check_count;
  logic [31:0]         rdat;
  logic                err;
  logic [21:0]         expv;
  int                  busy_cycles;
  int                  busy_base;
  // operand sets: dest, source, pair high, preloaded flags
  logic [7:0]          dv [4] = '{8'h7f, 8'h08, 8'h00, 8'hfe};
  logic [7:0]          sv [4] = '{8'h01, 8'h09, 8'h01, 8'h3f};
  logic [7:0]          hv [4] = '{8'hff, 8'h7f, 8'h80, 8'h7f};
  logic [5:0]          fv [4] = '{6'h3f, 6'h00, 6'h2a, 6'h01};

  ald_arith_logic_datapath ald_arith_logic_datapath_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .flags(flags));

  ald_decoder_model ald_decoder_model_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // busy cycles counted mid-cycle, where the output has settled
  always @(negedge pclk) begin
    busy_cycles <= busy_cycles + ((busy === 1'b1) ? 1 : 0);
  end

  // cut a hang short well past the expected 1300 or so cycles
  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // reference model: {pair high, dest, flags}
  // ----------------------------------------------------------------
  function automatic logic [21:0] model(input logic [3:0] op, input logic [7:0] d, s, hi,
                                        input ald_pkg::ald_flags_t f);
    logic [8:0]          r;
    logic [4:0]          lo;
    logic [16:0]         w;
    ald_pkg::ald_flags_t g;
    logic                ci;
    g  = f;
    ci = f.c & (op == 4'h1 || op == 4'h4 || op == 4'h5);
    r  = 9'h000;
    case (op) inside
      4'h0, 4'h1: begin
        r   = {1'b0, d} + {1'b0, s} + {8'h00, ci};
        lo  = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, ci};
        g.v = (d[7] == s[7]) && (r[7] != d[7]);
        g.c = r[8];
        g.h = lo[4];
      end
      [4'h2:4'h5]: begin
        r   = {1'b0, d} - {1'b0, s} - {8'h00, ci};
        lo  = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, ci};
        g.v = (d[7] != s[7]) && (r[7] != d[7]);
        g.c = r[8];
        g.h = lo[4];
      end
      4'h6, 4'h7: begin
        w   = (op == 4'h6) ? {1'b0, hi, d} + {11'h000, s[5:0]} : {1'b0, hi, d} - {11'h000, s[5:0]};
        g.v = (op == 4'h6) ? (!hi[7] & w[15]) : (hi[7] & !w[15]);
        g.c = (op == 4'h6) ? (!w[15] & hi[7]) : (w[15] & !hi[7]);
        g.n = w[15];
        g.z = (w[15:0] == 16'h0000);
        g.s = g.n ^ g.v;
        return {w[15:8], w[7:0], g};
      end
      default: begin
        r[7:0] = (op == 4'h8 || op == 4'h9) ? (d & s) : (op == 4'he) ? (d & (8'hff - s)) :
                 (op == 4'hc) ? d : (d | s);
        g.v    = 1'b0;
      end
    endcase
    g.n = r[7];
    g.z = (r[7:0] == 8'h00);
    return {hi, r[7:0], g};
  endfunction

  // ----------------------------------------------------------------
  // compare and bus helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic e);
    ald_decoder_model_inst.xfer(1'b1, a, {24'h000000, d}, 4'hf, rdat, err);
    chk({31'h0, err}, {31'h0, e});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
    ald_decoder_model_inst.xfer(1'b0, a, 32'h0, 4'h0, rdat, err);
    chk({31'h0, err}, {31'h0, e});
    chk(rdat, exp);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail      = 0;
    check_count = 0;
    presetn     = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // every register reads zero after reset
    for (int i = 0; i < 6; i++) rd(12'(4 * i), 32'h0, 1'b0);
    ald_decoder_model_inst.idle();
    // every opcode over every operand set; busy seen two edges on only for word ops
    for (int op = 0; op < 15; op++) begin
      for (int k = 0; k < 4; k++) begin
        expv = model(4'(op), dv[k], sv[k], hv[k], fv[k]);
        wr(`ALD_DEST_OFFS, dv[k], 1'b0);
        wr(`ALD_SRC_OFFS, sv[k], 1'b0);
        wr(`ALD_PAIR_HI_OFFS, hv[k], 1'b0);
        wr(`ALD_FLAGS_OFFS, {2'b00, fv[k]}, 1'b0);
        busy_base = busy_cycles;
        wr(`ALD_CMD_OFFS, 8'(op), 1'b0);
        ald_decoder_model_inst.idle();
        rd(`ALD_STAT_OFFS, {31'h0, op == 6 || op == 7}, 1'b0);
        ald_decoder_model_inst.idle();
        rd(`ALD_DEST_OFFS, {24'h0, expv[13:6]}, 1'b0);
        rd(`ALD_PAIR_HI_OFFS, {24'h0, expv[21:14]}, 1'b0);
        ald_decoder_model_inst.idle();
        chk({26'h0, flags}, {26'h0, expv[5:0]});
        rd(`ALD_FLAGS_OFFS, {26'h0, expv[5:0]}, 1'b0);
        chk(32'(busy_cycles - busy_base), (op == 6 || op == 7) ? 32'h2 : 32'h1);
      end
    end
    // write refused while a word operation runs
    wr(`ALD_SRC_OFFS, 8'h05, 1'b0);
    wr(`ALD_CMD_OFFS, 8'h06, 1'b0);
    wr(`ALD_SRC_OFFS, 8'h3c, 1'b1);
    ald_decoder_model_inst.idle();
    rd(`ALD_SRC_OFFS, 32'h05, 1'b0);
    // unmapped place refused, write without the byte 0 strobe ignored
    rd(12'h018, 32'h0, 1'b1);
    wr(12'h018, 8'h11, 1'b1);
    wr(`ALD_DEST_OFFS, 8'h5a, 1'b0);
    ald_decoder_model_inst.xfer(1'b1, `ALD_DEST_OFFS, 32'ha5, 4'he, rdat, err);
    chk({31'h0, err}, 32'h0);
    rd(`ALD_DEST_OFFS, 32'h5a, 1'b0);
    // illegal opcode starts nothing
    wr(`ALD_CMD_OFFS, 8'h0f, 1'b0);
    ald_decoder_model_inst.idle();
    rd(`ALD_STAT_OFFS, 32'h2, 1'b0);
    rd(`ALD_CMD_OFFS, 32'h6, 1'b0);
    rd(`ALD_DEST_OFFS, 32'h5a, 1'b0);
    ald_decoder_model_inst.idle();
    wrap_up();
  end
endmodule

`default_nettype wire
